// *** logic/sfdc_pkg.sv ***
// Constants, register map and carrier types for the sag/fault detector
// and calibration sequencer. Assumes a 32-bit Avalon-MM register bus.
package sfdc_pkg;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;
  localparam int NCHAN = 4;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_VDIP_WIN1 = 6'h00;
  localparam logic [5:0] IDX_VDIP_THR1 = 6'h01;
  localparam logic [5:0] IDX_CLOSS_WIN1 = 6'h04;
  localparam logic [5:0] IDX_CLOSS_THR1 = 6'h05;
  localparam logic [5:0] IDX_VDIP_WIN2 = 6'h08;
  localparam logic [5:0] IDX_VDIP_THR2 = 6'h09;
  localparam logic [5:0] IDX_CLOSS_WIN2 = 6'h0c;
  localparam logic [5:0] IDX_CLOSS_THR2 = 6'h0d;
  localparam logic [5:0] IDX_CYCLE_COUNT = 6'h10;
  localparam logic [5:0] IDX_CAL_CMD = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_MASK = 6'h13;
  localparam logic [5:0] IDX_DC_OFF0 = 6'h18;
  localparam logic [5:0] IDX_GAIN0 = 6'h1c;
  localparam logic [5:0] IDX_AC_OFF0 = 6'h20;
  // Reset values, gain limit, duration mask and AC gain numerator.
  localparam logic [23:0] RST_ZERO = 24'h000000;
  localparam logic [23:0] RST_CYCLE_COUNT = 24'h000fa0;
  localparam logic [23:0] GAIN_ONE = 24'h400000;
  localparam logic [23:0] GAIN_MAX = 24'hffffff;
  localparam logic [23:0] DUR_MASK = 24'h7fffff;
  localparam logic [23:0] AC_GAIN_NUM = 24'h266666;
  // Extra conversions beyond N, or beyond six N for AC offset, in every calibration.
  localparam logic [27:0] CAL_EXTRA = 28'h000001e;
  localparam logic [27:0] AC_MULT = 28'h0000006;
  // Status bits.
  localparam int ST_READY = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_EVT0 = 4;
  // Calibration command field: [1:0] channel, [4:2] type.
  localparam logic [2:0] CAL_DC_OFF = 3'h1;
  localparam logic [2:0] CAL_AC_OFF = 3'h2;
  localparam logic [2:0] CAL_AC_GAIN = 3'h3;
  localparam logic [2:0] CAL_DC_GAIN = 3'h4;
  typedef struct packed {
    logic [23:0] win;
    logic [23:0] thr;
  } sfdc_mon_cfg_type;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_DONE = 3'b100
  } sfdc_cal_state_type;
endpackage : sfdc_pkg

// *** logic/sfdc_top.sv ***
// Sag/fault detection, sample correction and calibration sequencer.
// Assumes signed 24-bit samples with a one-cycle valid strobe per channel
// (0 voltage ch1, 1 current ch1, 2 voltage ch2, 3 current ch2) from logic
// on the same clock, and an Avalon-MM master with waitrequest.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Each monitor window length, in samples, comes from its duration register.
// - A zero duration register disables that monitor completely.
// - Flag voltage dip when averaged sample magnitude falls below threshold.
// - Flag current loss when averaged sample magnitude falls below threshold.
// - Thresholds are unsigned 24-bit fractions, MSB weighs one half.
// - Duration top bit is always zero; 23 usable bits, one sample per LSB.
// - Offset and gain corrections apply to samples; AC offset is stored but applied to nothing.
// - Each channel keeps its own offset and gain registers.
// - Calibration averaging window is sized from cycle count N.
// - On completion store result and set the ready flag in status.
// - Interrupt pin shows completion only when the mask ready bit is set.
// - Calibration measures the signal already corrected by present registers.
// - DC offset and gain calibrations last at least N plus 30 conversions.
// - AC offset calibration lasts at least six N plus 30 conversions.
// - DC offset calibration stores the negated sample mean.
// - AC gain calibration stores 0.6 divided by measured RMS.
// - DC gain calibration resets gain to one, stores one over the mean.
// - Gain never exceeds four; larger need marks the result invalid.
module sfdc_top
  import sfdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Avalon-MM slave.
  input wire logic [sfdc_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Sample stream.
  input wire logic [sfdc_pkg::NCHAN-1:0] smp_valid_in,
  input wire logic [sfdc_pkg::NCHAN*24-1:0] smp_data_in,
  // Corrected samples and status.
  output logic [sfdc_pkg::NCHAN-1:0] corr_valid_out,
  output logic [sfdc_pkg::NCHAN*24-1:0] corr_data_out,
  output logic int_out
);
  import sfdc_pkg::*;

  sfdc_mon_cfg_type mon_cfg_r [NCHAN];
  logic [23:0] dc_off_r [NCHAN];
  logic [23:0] gain_r [NCHAN];
  logic [23:0] ac_off_r [NCHAN];
  logic [23:0] cycle_count_r;
  logic [23:0] mask_r;
  logic [23:0] status_r;
  logic [23:0] set_bits;
  logic [NCHAN-1:0] evt;
  logic [23:0] corr [NCHAN];
  logic [23:0] mag [NCHAN];
  logic [47:0] msum_r [NCHAN];
  logic [22:0] mcnt_r [NCHAN];
  logic ack_r;
  logic wr_go;
  logic rd_go;
  sfdc_cal_state_type cal_state_r;
  logic [2:0] cal_type_r;
  logic [1:0] cal_ch_r;
  logic [27:0] cal_cnt_r;
  logic [27:0] cal_len_r;
  logic [27:0] acc_n_r;
  logic signed [55:0] cal_sum_r;
  logic [71:0] cal_sq_r;
  logic [23:0] cal_result;
  logic cal_bad;
  logic cal_start;

  function automatic logic [23:0] abs24(input logic [23:0] v);
    abs24 = v[23] ? 24'(-v) : v;
  endfunction : abs24

  function automatic logic [23:0] sqrt48(input logic [47:0] v);
    logic [23:0] r;
    r = 24'h000000;
    for (int b = 23; b >= 0; b--)
    begin
      r[b] = 1'b1;
      if (48'(r) * 48'(r) > v)
      begin
        r[b] = 1'b0;
      end
    end
    sqrt48 = r;
  endfunction : sqrt48

  // Bus handshake: one wait cycle, then the access completes.
  assign wr_go = avs_write_in & ~ack_r;
  assign rd_go = avs_read_in & ~ack_r;
  assign cal_start = wr_go && avs_address_in == IDX_CAL_CMD &&
                     cal_state_r == CAL_IDLE;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ack_r <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_r);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      avs_readdata_out <= 32'h00000000;
    else if (rd_go)
    begin
      avs_readdata_out <= 32'h00000000;
      for (int c = 0; c < NCHAN; c++)
      begin
        if (avs_address_in == 6'(4 * c))
          avs_readdata_out <= {8'h00, mon_cfg_r[c].win};
        if (avs_address_in == 6'(4 * c + 1))
          avs_readdata_out <= {8'h00, mon_cfg_r[c].thr};
        if (avs_address_in == IDX_DC_OFF0 + 6'(c))
          avs_readdata_out <= {8'h00, dc_off_r[c]};
        if (avs_address_in == IDX_GAIN0 + 6'(c))
          avs_readdata_out <= {8'h00, gain_r[c]};
        if (avs_address_in == IDX_AC_OFF0 + 6'(c))
          avs_readdata_out <= {8'h00, ac_off_r[c]};
      end
      case (avs_address_in)
        IDX_CYCLE_COUNT: avs_readdata_out <= {8'h00, cycle_count_r};
        IDX_CAL_CMD: avs_readdata_out <= {27'h0, cal_type_r, cal_ch_r};
        IDX_STATUS: avs_readdata_out <= {8'h00, status_r};
        IDX_MASK: avs_readdata_out <= {8'h00, mask_r};
        default: ;
      endcase
    end
  end

  // Sample correction and dip/loss monitors, one per channel.
  genvar g;
  generate
    for (g = 0; g < NCHAN; g++)
    begin : gen_ch
      logic [47:0] prod;
      logic [23:0] offs;
      assign offs = 24'(smp_data_in[g*24 +: 24] + dc_off_r[g]);
      assign prod = 48'($signed(offs) * $signed({1'b0, gain_r[g]}));
      assign corr[g] = prod[45:22];
      assign mag[g] = abs24(corr[g]);

      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          corr_valid_out[g] <= 1'b0;
          corr_data_out[g*24 +: 24] <= RST_ZERO;
        end
        else
        begin
          corr_valid_out[g] <= smp_valid_in[g];
          corr_data_out[g*24 +: 24] <= corr[g];
        end
      end

      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          msum_r[g] <= 48'h0;
          mcnt_r[g] <= 23'h0;
          evt[g] <= 1'b0;
        end
        else if (mon_cfg_r[g].win == RST_ZERO)
        begin
          msum_r[g] <= 48'h0;
          mcnt_r[g] <= 23'h0;
          evt[g] <= 1'b0;
        end
        else if (smp_valid_in[g])
        begin
          if (24'(mcnt_r[g] + 23'h1) == mon_cfg_r[g].win)
          begin
            // Threshold LSB is half a sample LSB, so the sum is doubled.
            evt[g] <= {msum_r[g] + 48'(mag[g]), 1'b0} <
                      49'(48'(mon_cfg_r[g].thr) * 48'(mon_cfg_r[g].win));
            msum_r[g] <= 48'h0;
            mcnt_r[g] <= 23'h0;
          end
          else
          begin
            evt[g] <= 1'b0;
            msum_r[g] <= msum_r[g] + 48'(mag[g]);
            mcnt_r[g] <= mcnt_r[g] + 23'h1;
          end
        end
        else
        begin
          evt[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Configuration and correction registers.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cycle_count_r <= RST_CYCLE_COUNT;
      mask_r <= RST_ZERO;
      for (int c = 0; c < NCHAN; c++)
      begin
        mon_cfg_r[c] <= '{win: RST_ZERO, thr: RST_ZERO};
        dc_off_r[c] <= RST_ZERO;
        gain_r[c] <= GAIN_ONE;
        ac_off_r[c] <= RST_ZERO;
      end
    end
    else
    begin
      if (wr_go)
      begin
        for (int c = 0; c < NCHAN; c++)
        begin
          if (avs_address_in == 6'(4 * c))
            mon_cfg_r[c].win <= avs_writedata_in[23:0] & DUR_MASK;
          if (avs_address_in == 6'(4 * c + 1))
            mon_cfg_r[c].thr <= avs_writedata_in[23:0];
          if (avs_address_in == IDX_DC_OFF0 + 6'(c))
            dc_off_r[c] <= avs_writedata_in[23:0];
          if (avs_address_in == IDX_GAIN0 + 6'(c))
            gain_r[c] <= avs_writedata_in[23:0];
          if (avs_address_in == IDX_AC_OFF0 + 6'(c))
            ac_off_r[c] <= avs_writedata_in[23:0];
        end
        if (avs_address_in == IDX_CYCLE_COUNT)
          cycle_count_r <= avs_writedata_in[23:0];
        if (avs_address_in == IDX_MASK)
          mask_r <= avs_writedata_in[23:0];
      end
      if (cal_start && avs_writedata_in[4:2] == CAL_DC_GAIN)
        gain_r[avs_writedata_in[1:0]] <= GAIN_ONE;
      if (cal_state_r == CAL_DONE)
      begin
        case (cal_type_r)
          CAL_DC_OFF: dc_off_r[cal_ch_r] <= cal_result;
          CAL_AC_OFF: ac_off_r[cal_ch_r] <= cal_result;
          CAL_AC_GAIN, CAL_DC_GAIN: gain_r[cal_ch_r] <= cal_result;
          default: ;
        endcase
      end
    end
  end

  // Calibration sequencer.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cal_state_r <= CAL_IDLE;
      cal_type_r <= 3'h0;
      cal_ch_r <= 2'h0;
      cal_cnt_r <= 28'h0;
      cal_len_r <= 28'h0;
      acc_n_r <= 28'h0;
      cal_sum_r <= 56'sh0;
      cal_sq_r <= 72'h0;
    end
    else
    begin
      case (cal_state_r)
        CAL_IDLE:
        begin
          if (cal_start)
          begin
            cal_type_r <= avs_writedata_in[4:2];
            cal_ch_r <= avs_writedata_in[1:0];
            cal_cnt_r <= 28'h0;
            acc_n_r <= 28'h0;
            cal_sum_r <= 56'sh0;
            cal_sq_r <= 72'h0;
            cal_len_r <= (avs_writedata_in[4:2] == CAL_AC_OFF) ?
                         28'(AC_MULT * 28'(cycle_count_r)) + CAL_EXTRA :
                         28'(cycle_count_r) + CAL_EXTRA;
            cal_state_r <= CAL_RUN;
          end
        end
        CAL_RUN:
        begin
          if (smp_valid_in[cal_ch_r])
          begin
            cal_cnt_r <= cal_cnt_r + 28'h1;
            if (cal_cnt_r >= cal_len_r - 28'(cycle_count_r))
            begin
              acc_n_r <= acc_n_r + 28'h1;
              cal_sum_r <= cal_sum_r + 56'(signed'(corr[cal_ch_r]));
              cal_sq_r <= cal_sq_r + 72'(mag[cal_ch_r]) *
                          72'(mag[cal_ch_r]);
            end
            if (cal_cnt_r + 28'h1 >= cal_len_r)
              cal_state_r <= CAL_DONE;
          end
        end
        CAL_DONE: cal_state_r <= CAL_IDLE;
        default: cal_state_r <= CAL_IDLE;
      endcase
    end
  end

  // Result arithmetic for the finished calibration.
  always_comb
  begin
    logic signed [55:0] mean;
    logic [23:0] rms;
    logic [47:0] quo;
    logic [23:0] den;
    mean = cal_sum_r / $signed({28'h0, (acc_n_r == 28'h0) ? 28'h1 : acc_n_r});
    rms = sqrt48(48'(cal_sq_r / 72'((acc_n_r == 28'h0) ? 28'h1 : acc_n_r)));
    den = 24'h0;
    quo = 48'h0;
    cal_result = RST_ZERO;
    cal_bad = 1'b0;
    case (cal_type_r)
      CAL_DC_OFF: cal_result = 24'(-mean);
      CAL_AC_OFF: cal_result = rms;
      CAL_AC_GAIN, CAL_DC_GAIN:
      begin
        den = (cal_type_r == CAL_AC_GAIN) ? rms : abs24(24'(mean));
        quo = (cal_type_r == CAL_AC_GAIN) ?
              {1'b0, AC_GAIN_NUM, 23'h0} : {1'b0, GAIN_ONE, 23'h0};
        quo = quo / 48'((den == 24'h0) ? 24'h1 : den);
        cal_bad = (den == 24'h0) || (quo[47:24] != 24'h0);
        cal_result = cal_bad ? GAIN_MAX : quo[23:0];
      end
      default: ;
    endcase
  end

  // Status: set wins over a write-one-to-clear in the same cycle.
  always_comb
  begin
    set_bits = 24'h0;
    set_bits[ST_READY] = (cal_state_r == CAL_DONE);
    set_bits[ST_INVALID] = (cal_state_r == CAL_DONE) & cal_bad;
    set_bits[ST_EVT0 +: NCHAN] = evt;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status_r <= RST_ZERO;
    else if (wr_go && avs_address_in == IDX_STATUS)
      status_r <= (status_r & ~avs_writedata_in[23:0]) | set_bits;
    else
      status_r <= status_r | set_bits;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      int_out <= 1'b0;
    else
      int_out <= |(status_r & mask_r);
  end
endmodule : sfdc_top

// *** bench/sfdc_chk.sv ***
// Checker for the bus, sample stream and interrupt ports of sfdc_top.
// Assumes it is bound to sfdc_top and sees only its ports.
`timescale 1ns/100ps
module sfdc_chk
  import sfdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register bus.
  input wire logic [sfdc_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Stream and interrupt.
  input wire logic [sfdc_pkg::NCHAN-1:0] smp_valid_in,
  input wire logic [sfdc_pkg::NCHAN-1:0] corr_valid_out,
  input wire logic int_out
);
  logic wr_ack;
  logic [7:0] mask_r;
  logic [23:0] ncnt_r;
  logic [23:0] cyc_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  assign wr_ack = avs_write_in && !avs_waitrequest_out;
  // Tracks the mask, the cycle count and cycles since a command.
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      mask_r <= 8'h00;
    else if (wr_ack && avs_address_in == IDX_MASK)
      mask_r <= avs_writedata_in[7:0];
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      ncnt_r <= RST_CYCLE_COUNT;
    else if (wr_ack && avs_address_in == IDX_CYCLE_COUNT)
      ncnt_r <= avs_writedata_in[23:0];
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      cyc_r <= 24'hffffff;
    else if (wr_ack && avs_address_in == IDX_CAL_CMD)
      cyc_r <= 24'h000000;
    else if (cyc_r != 24'hffffff)
      cyc_r <= cyc_r + 24'h000001;
  chk_wait_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("request not answered in the next cycle");
  chk_wait_pulse: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  chk_wait_cause: assert property (
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("answer without a request");
  chk_read_hold: assert property (
    avs_waitrequest_out |-> $stable(avs_readdata_out))
    else $error("read data changed without a read");
  chk_read_top: assert property (
    avs_readdata_out[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  chk_corr_follow: assert property (
    smp_valid_in != 4'h0 |=> corr_valid_out == $past(smp_valid_in))
    else $error("corrected strobe does not follow sample strobe");
  chk_corr_quiet: assert property (
    smp_valid_in == 4'h0 |=> corr_valid_out == 4'h0)
    else $error("corrected strobe without a sample");
  chk_int_masked: assert property (
    int_out |-> (mask_r | $past(mask_r)) != 8'h00)
    else $error("interrupt with all mask bits clear");
  chk_cal_len: assert property (
    $rose(int_out) && mask_r[7:4] == 4'h0 |-> cyc_r >= ncnt_r + 24'h00001e)
    else $error("calibration finished too early");
endmodule : sfdc_chk
bind sfdc_top sfdc_chk u_sfdc_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .smp_valid_in(smp_valid_in), .corr_valid_out(corr_valid_out),
  .int_out(int_out));

// *** bench/sfdc_host_model.sv ***
// Host controller model: issues register transfers on the Avalon-MM bus.
// Assumes one clock shared with the device.
`timescale 1ns/100ps
module sfdc_host_model
  import sfdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Avalon-MM master.
  output logic [sfdc_pkg::ADDR_W-1:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  input wire logic [31:0] avs_readdata_in,
  input wire logic avs_waitrequest_in
);
  initial
  begin
    avs_address_out = 6'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_in);
    if (reset_n_in !== 1'b1)
      return;
    avs_address_out <= a;
    avs_read_out <= !w;
    avs_write_out <= w;
    avs_writedata_out <= d;
    for (n = 0; n < 50 && !ok; n++)
    begin
      @(posedge clk_in);
      ok = (avs_waitrequest_in === 1'b0);
    end
    q = avs_readdata_in;
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
    avs_address_out <= ~a;
    avs_writedata_out <= ~d;
  endtask : xfer
endmodule : sfdc_host_model

// *** bench/sfdc_top_tb_top.sv ***
// Self-checking bench for sfdc_top: registers, monitors and calibration.
// Assumes the host model drives the bus and the bench drives samples.
`timescale 1ns/100ps
module sfdc_top_tb_top;
  import sfdc_pkg::*;
  logic clk_in;
  logic reset_n_in;
  logic [5:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] sv;
  logic [95:0] sd;
  logic [3:0] cv;
  logic [95:0] cd;
  logic irq;
  int num_errors;
  int n_checks;
  logic [5:0] mreg [8] = '{IDX_VDIP_WIN1, IDX_VDIP_THR1, IDX_CLOSS_WIN1,
    IDX_CLOSS_THR1, IDX_VDIP_WIN2, IDX_VDIP_THR2, IDX_CLOSS_WIN2,
    IDX_CLOSS_THR2};
  sfdc_top u_sfdc_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .smp_valid_in(sv), .smp_data_in(sd),
    .corr_valid_out(cv), .corr_data_out(cd), .int_out(irq));
  sfdc_host_model u_sfdc_host_model (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .avs_address_out(addr),
    .avs_read_out(rd_s), .avs_write_out(wr_s),
    .avs_writedata_out(wdata), .avs_readdata_in(rdata),
    .avs_waitrequest_in(wreq));
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    logic ok;
    u_sfdc_host_model.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      num_errors++;
      close_out;
    end
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic smp(input logic [3:0] m, input logic [23:0] v);
    @(posedge clk_in);
    sv <= m;
    sd <= {4{v}};
    @(posedge clk_in);
    sv <= 4'h0;
    sd <= ~{4{v}};
  endtask : smp
  task automatic t_regs;
    logic [31:0] q;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, mreg[i], 0, q);
      chk("reset value", q, 32'h0);
    end
    bus(1'b0, IDX_CYCLE_COUNT, 0, q);
    chk("cycle count", q, {8'h00, RST_CYCLE_COUNT});
    bus(1'b0, 6'h3f, 0, q);
    chk("unmapped", q, 32'h0);
    wr(IDX_VDIP_WIN1, 32'hffffffff);
    bus(1'b0, IDX_VDIP_WIN1, 0, q);
    chk("window top bit", q, {8'h00, DUR_MASK});
    wr(IDX_VDIP_THR1, 32'h00ffffff);
    bus(1'b0, IDX_VDIP_THR1, 0, q);
    chk("threshold", q, 32'h00ffffff);
  endtask : t_regs
  task automatic t_mon;
    logic [31:0] q;
    wr(IDX_STATUS, 32'hff);
    for (int i = 0; i < 4; i++)
    begin
      wr(mreg[2*i], (i == 2) ? 32'h0 : 32'h3);
      wr(mreg[2*i+1], 32'h800000);
    end
    repeat (3) smp(4'hf, 24'hffff00);
    @(negedge clk_in);
    chk("corrected 0", {8'h00, cd[23:0]}, 32'h00ffff00);
    chk("corrected 3", {8'h00, cd[95:72]}, 32'h00ffff00);
    bus(1'b0, IDX_STATUS, 0, q);
    chk("events", q, 32'hb0);
    bus(1'b0, IDX_STATUS, 0, q);
    chk("events held", q, 32'hb0);
    wr(IDX_STATUS, 32'hf0);
    repeat (3) smp(4'hf, 24'h600000);
    bus(1'b0, IDX_STATUS, 0, q);
    chk("no events", q, 32'h0);
  endtask : t_mon
  task automatic cal(input int ch, input logic [2:0] t,
      input logic [23:0] v, input int lmin);
    logic [31:0] q;
    int n;
    wr(IDX_STATUS, 32'h3);
    wr(IDX_CAL_CMD, {27'h0, t, ch[1:0]});
    q = 32'h0;
    for (n = 0; n < 400 && q[0] !== 1'b1; n++)
    begin
      smp(4'h1 << ch, v);
      bus(1'b0, IDX_STATUS, 0, q);
    end
    chk("cal ready", {31'h0, q[0]}, 32'h1);
    chk("cal length", 32'(n), 32'(lmin));
  endtask : cal
  task automatic t_cal;
    logic [31:0] q;
    wr(IDX_CYCLE_COUNT, 32'h4);
    wr(IDX_MASK, 32'h1);
    cal(0, CAL_DC_OFF, 24'h000100, 34);
    bus(1'b0, IDX_DC_OFF0, 0, q);
    chk("dc offset", q, 32'h00ffff00);
    bus(1'b0, IDX_DC_OFF0 + 6'h1, 0, q);
    chk("other offset", q, 32'h0);
    chk("irq shown", {31'h0, irq}, 32'h1);
    smp(4'h1, 24'h000100);
    @(negedge clk_in);
    chk("offset applied", {8'h00, cd[23:0]}, 32'h0);
    wr(IDX_MASK, 32'h0);
    cal(1, CAL_DC_GAIN, 24'h400000, 34);
    bus(1'b0, IDX_GAIN0 + 6'h1, 0, q);
    chk("dc gain", q, 32'h800000);
    chk("irq masked", {31'h0, irq}, 32'h0);
    cal(1, CAL_DC_GAIN, 24'h100000, 34);
    bus(1'b0, IDX_GAIN0 + 6'h1, 0, q);
    chk("gain limit", q, {8'h00, GAIN_MAX});
    bus(1'b0, IDX_STATUS, 0, q);
    chk("invalid", q & 32'h3, 32'h3);
    bus(1'b0, IDX_GAIN0, 0, q);
    chk("gain kept", q, {8'h00, GAIN_ONE});
    cal(3, CAL_AC_GAIN, 24'h266666, 34);
    bus(1'b0, IDX_GAIN0 + 6'h3, 0, q);
    chk("ac gain", q, 32'h00800000);
    wr(IDX_CYCLE_COUNT, 32'h2);
    wr(IDX_DC_OFF0 + 6'h2, 32'h00100000);
    cal(2, CAL_AC_OFF, 24'h023456, 42);
    bus(1'b0, IDX_AC_OFF0 + 6'h2, 0, q);
    chk("ac offset", q, 32'h00123456);
  endtask : t_cal
  initial
  begin
    reset_n_in = 1'b0;
    sv = 4'h0;
    sd = 96'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_regs;
    t_mon;
    t_cal;
    close_out;
  end
endmodule : sfdc_top_tb_top
